// file: bfs_flag_sync.sv
// Purpose: Flags, port decode and queues of a two-port bidirectional FIFO
// Assumes: Port clocks are slow pins sampled by hclk; AHB-Lite holds setup
// Notes:   Port accesses happen on the hclk cycle a port edge is found; output enable follows select in read direction
// How it works
// - every queue flag is built from pointers passed through two flops
// - port A flags only change on port A clock edges or register writes
// - port B flags only change on port B clock edges or register writes
// - port A select, direction, enable, mailbox select decode its access
// - a port A mailbox read sets the second mailbox flag high
// - port B decodes with inverted direction sense
// - a port B mailbox read sets the first mailbox flag high
// - fall-through output-ready is high only with a new output word
// - fall-through reads are ignored while output-ready is low
// - standard empty flag high means a word waits; otherwise reads ignored
// - the read pointer steps each time the output register loads
// - fall-through word lands on the third reader edge with output-ready
// - standard empty flag rises on the second reader edge after a write
// - a write too near a reader edge counts from the following edge
// - input-ready is high while a location is free; else writes ignored
// - the write pointer steps on every accepted word
// - full clears on the second writer edge after the freeing read
// - a read too near a writer edge counts from the following edge
// - A to B almost-empty low up to its offset; empty low at zero
// - A to B almost-full low at depth minus offset, full at depth
// - B to A queue uses the same thresholds on swapped ports
// - words in the output register are not counted as stored
// - flag pins carry ready flags in fall-through, empty/full otherwise
// - with output-ready low the next word falls through automatically
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ns
module bfs_flag_sync #(
  parameter int DEPTH = bfs_pkg::DEPTH_DEF
) (
  // System
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // Port A
  input  wire logic                       port_a_clock,
  input  wire logic                       port_a_select_n,
  input  wire logic                       port_a_direction,
  input  wire logic                       port_a_enable,
  input  wire logic                       port_a_mailbox_select,
  input  wire logic [bfs_pkg::DATA_W-1:0] port_a_data_in,
  output logic      [bfs_pkg::DATA_W-1:0] port_a_data_out,
  output logic                            port_a_data_oe,
  output logic                            port_a_empty_or_out_ready,
  output logic                            port_a_almost_empty_n,
  output logic                            port_a_full_or_in_ready,
  output logic                            port_a_almost_full_n,
  // Port B
  input  wire logic                       port_b_clock,
  input  wire logic                       port_b_select_n,
  input  wire logic                       port_b_direction,
  input  wire logic                       port_b_enable,
  input  wire logic                       port_b_mailbox_select,
  input  wire logic [bfs_pkg::DATA_W-1:0] port_b_data_in,
  output logic      [bfs_pkg::DATA_W-1:0] port_b_data_out,
  output logic                            port_b_data_oe,
  output logic                            port_b_empty_or_out_ready,
  output logic                            port_b_almost_empty_n,
  output logic                            port_b_full_or_in_ready,
  output logic                            port_b_almost_full_n,
  // Mailbox flags
  output logic                            mailbox_one_full_n,
  output logic                            mailbox_two_full_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = bfs_pkg::PTR_W;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  if (DEPTH != 256 && DEPTH != 512 && DEPTH != 1024) begin : g_chk
    $error("DEPTH must be 256, 512 or 1024");
  end

  bfs_pkg::bfs_state_t st_q;
  bfs_pkg::bfs_state_t st_d;
  bfs_pkg::bfs_pin_t   pin_in [2];
  bfs_pkg::bfs_pin_t   c;

  logic [bfs_pkg::DATA_W-1:0] mem [2][DEPTH];

  logic [1:0]    edge_p;
  logic [1:0]    wr_req;
  logic [1:0]    rd_req;
  logic [1:0]    mbw_req;
  logic [1:0]    mbr_req;
  logic [1:0]    wr_ok;
  logic [1:0]    rd_ok;
  logic [1:0]    load;
  logic [1:0]    fill_r;
  logic [1:0]    eor;
  logic [1:0]    ae_n;
  logic [1:0]    full_n;
  logic [1:0]    af_n;
  logic [PW-1:0] cnt_r [2];
  logic [PW-1:0] cnt_w [2];
  logic          act;
  logic          wdir;
  logic [7:0]    raddr;
  logic [31:0]   rdat;

  assign pin_in[0] = '{port_a_clock, port_a_select_n, port_a_direction,
                       port_a_enable, port_a_mailbox_select, port_a_data_in};
  assign pin_in[1] = '{port_b_clock, port_b_select_n, port_b_direction,
                       port_b_enable, port_b_mailbox_select, port_b_data_in};

  always_comb begin
    st_d  = st_q;
    c     = st_q.port[0].s3;
    act   = 1'b0;
    wdir  = 1'b0;
    raddr = haddr[7:0];
    rdat  = 32'h0000_0000;
    // Pin sampling and access decode per port
    for (int p = 0; p < 2; p++) begin
      st_d.port[p].s1 = pin_in[p];
      st_d.port[p].s2 = st_q.port[p].s1;
      st_d.port[p].s3 = st_q.port[p].s2;
      c = st_q.port[p].s3;
      // Controls are taken from the sample before the clock was seen high
      edge_p[p] = st_q.port[p].s2.clk & ~c.clk;
      act = edge_p[p] & ~c.select_n & c.enable;
      wdir = (c.direction == bfs_pkg::WR_DIR[p]);
      wr_req[p]  = act & wdir & ~c.mailbox_select;
      rd_req[p]  = act & ~wdir & ~c.mailbox_select;
      mbw_req[p] = act & wdir & c.mailbox_select;
      mbr_req[p] = act & ~wdir & c.mailbox_select;
      st_d.port[p].doe  = ~c.select_n & ~wdir;
      st_d.port[p].dout = c.mailbox_select ? st_q.mb_data[1-p] : st_q.q[1-p].dout;
    end
    // Queue q is written by port q and read by the other port
    for (int q = 0; q < 2; q++) begin
      // Stored count excludes the output register word
      cnt_r[q] = bfs_pkg::bfs_from_gray(st_q.q[q].ws2) - st_q.q[q].rbin;
      cnt_w[q] = st_q.q[q].wbin - bfs_pkg::bfs_from_gray(st_q.q[q].rs2);
      fill_r[q] = (cnt_r[q] != '0);
      ae_n[q] = (cnt_r[q] > PW'(st_q.empty_off[q]));
      full_n[q] = (cnt_w[q] != DEPTH_P);
      af_n[q] = (cnt_w[q] < (DEPTH_P - PW'(st_q.full_off[q])));
      eor[q] = st_q.fall_through_mode ? st_q.q[q].out_valid : fill_r[q];
      rd_ok[q] = rd_req[1-q] & eor[q];
      wr_ok[q] = wr_req[q] & full_n[q];
      if (st_q.fall_through_mode) begin
        load[q] = fill_r[q] & (st_q.q[q].out_valid ? rd_ok[q] : edge_p[1-q]);
      end else begin
        load[q] = rd_ok[q];
      end
      if (st_q.fall_through_mode && rd_ok[q] && !fill_r[q]) begin
        st_d.q[q].out_valid = 1'b0;
      end
      if (load[q]) begin
        st_d.q[q].dout = mem[q][st_q.q[q].rbin[AW-1:0]];
        st_d.q[q].rbin = st_q.q[q].rbin + 1'b1;
        st_d.q[q].rgray = bfs_pkg::bfs_to_gray(st_d.q[q].rbin);
        st_d.q[q].out_valid = st_q.fall_through_mode;
      end
      if (!st_q.fall_through_mode) begin
        st_d.q[q].out_valid = 1'b0;
      end
      if (wr_ok[q]) begin
        st_d.q[q].wbin = st_q.q[q].wbin + 1'b1;
        st_d.q[q].wgray = bfs_pkg::bfs_to_gray(st_d.q[q].wbin);
      end
      // Two-stage pointer synchronisers, stepped by the far port's clock
      if (edge_p[1-q]) begin
        st_d.q[q].ws1 = st_q.q[q].wgray;
        st_d.q[q].ws2 = st_q.q[q].ws1;
      end
      if (edge_p[q]) begin
        st_d.q[q].rs1 = st_q.q[q].rgray;
        st_d.q[q].rs2 = st_q.q[q].rs1;
      end
    end
    // Mailboxes: port p writes mailbox p and reads the other one
    for (int p = 0; p < 2; p++) begin
      if (mbr_req[p]) begin
        st_d.mb_full_n[1-p] = 1'b1;
      end
    end
    for (int p = 0; p < 2; p++) begin
      // Writes are refused while the mailbox still holds unread mail
      if (mbw_req[p] && st_q.mb_full_n[p]) begin
        st_d.mb_data[p]   = st_q.port[p].s3.data;
        st_d.mb_full_n[p] = 1'b0;
      end
    end
    // AHB data phase of a write
    if (st_q.wr_pend) begin
      case (st_q.waddr)
        bfs_pkg::ADDR_CTRL: begin
          st_d.fall_through_mode = hwdata[bfs_pkg::CTRL_FALL_THROUGH_MODE];
        end
        bfs_pkg::ADDR_OFF_AB: begin
          st_d.empty_off[0] = hwdata[bfs_pkg::OFF_EMPTY_LSB +: bfs_pkg::OFF_W];
          st_d.full_off[0]  = hwdata[bfs_pkg::OFF_FULL_LSB +: bfs_pkg::OFF_W];
        end
        bfs_pkg::ADDR_OFF_BA: begin
          st_d.empty_off[1] = hwdata[bfs_pkg::OFF_EMPTY_LSB +: bfs_pkg::OFF_W];
          st_d.full_off[1]  = hwdata[bfs_pkg::OFF_FULL_LSB +: bfs_pkg::OFF_W];
        end
        default: begin
        end
      endcase
    end
    // AHB address phase; reads see a write finishing in the same cycle
    st_d.wr_pend = hsel & hready & htrans[1] & hwrite;
    st_d.waddr   = haddr[7:0];
    case (raddr)
      bfs_pkg::ADDR_CTRL: begin
        rdat[bfs_pkg::CTRL_FALL_THROUGH_MODE] = st_d.fall_through_mode;
      end
      bfs_pkg::ADDR_OFF_AB: begin
        rdat[bfs_pkg::OFF_EMPTY_LSB +: bfs_pkg::OFF_W] = st_d.empty_off[0];
        rdat[bfs_pkg::OFF_FULL_LSB +: bfs_pkg::OFF_W]  = st_d.full_off[0];
      end
      bfs_pkg::ADDR_OFF_BA: begin
        rdat[bfs_pkg::OFF_EMPTY_LSB +: bfs_pkg::OFF_W] = st_d.empty_off[1];
        rdat[bfs_pkg::OFF_FULL_LSB +: bfs_pkg::OFF_W]  = st_d.full_off[1];
      end
      bfs_pkg::ADDR_STATUS: begin
        rdat[3:0] = {af_n[0], full_n[0], ae_n[1], eor[1]};
        rdat[bfs_pkg::STAT_B_LSB +: 4] = {af_n[1], full_n[1], ae_n[0], eor[0]};
        rdat[bfs_pkg::STAT_MB_LSB +: 2] = st_q.mb_full_n;
      end
      default: begin
      end
    endcase
    if (hsel && hready && htrans[1] && !hwrite) begin
      st_d.hrdata = rdat;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q           <= '0;
      st_q.mb_full_n <= 2'h3;
      st_q.empty_off <= {2{bfs_pkg::OFF_RST}};
      st_q.full_off  <= {2{bfs_pkg::OFF_RST}};
      // Idle select level, so no output enable pulse follows reset
      for (int p = 0; p < 2; p++) begin
        st_q.port[p].s1.select_n <= 1'b1;
        st_q.port[p].s2.select_n <= 1'b1;
        st_q.port[p].s3.select_n <= 1'b1;
      end
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge hclk) begin
    for (int q = 0; q < 2; q++) begin
      if (wr_ok[q]) begin
        mem[q][st_q.q[q].wbin[AW-1:0]] <= st_q.port[q].s3.data;
      end
    end
  end

  assign hrdata    = st_q.hrdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign port_a_data_out           = st_q.port[0].dout;
  assign port_a_data_oe            = st_q.port[0].doe;
  assign port_a_empty_or_out_ready = eor[1];
  assign port_a_almost_empty_n     = ae_n[1];
  assign port_a_full_or_in_ready   = full_n[0];
  assign port_a_almost_full_n      = af_n[0];
  assign port_b_data_out           = st_q.port[1].dout;
  assign port_b_data_oe            = st_q.port[1].doe;
  assign port_b_empty_or_out_ready = eor[0];
  assign port_b_almost_empty_n     = ae_n[0];
  assign port_b_full_or_in_ready   = full_n[1];
  assign port_b_almost_full_n      = af_n[1];
  assign mailbox_one_full_n        = st_q.mb_full_n[0];
  assign mailbox_two_full_n        = st_q.mb_full_n[1];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  flag_a_sync_a: assert property (
    $changed(port_a_full_or_in_ready) |-> $past(edge_p[0]))
    else $error("port A full flag moved without a port A edge");
  flag_b_sync_a: assert property (
    $changed(port_b_full_or_in_ready) |-> $past(edge_p[1]))
    else $error("port B full flag moved without a port B edge");
  mbox_two_clr_a: assert property (
    mbr_req[0] |=> mailbox_two_full_n)
    else $error("port A mailbox read did not free mailbox two");
  mbox_one_clr_a: assert property (
    mbr_req[1] |=> mailbox_one_full_n)
    else $error("port B mailbox read did not free mailbox one");
  std_rd_ignore_a: assert property (
    !st_q.fall_through_mode && rd_req[1] && !port_b_empty_or_out_ready |=> $stable(st_q.q[0].rbin))
    else $error("standard read taken while empty");
  ft_rd_ignore_a: assert property (
    st_q.fall_through_mode && rd_req[0] && !st_q.q[1].out_valid && !fill_r[1]
    |=> $stable(st_q.q[1].dout) && !port_a_empty_or_out_ready)
    else $error("fall-through read taken while not ready");
  wr_ignore_a: assert property (
    wr_req[0] && !port_a_full_or_in_ready |=> $stable(st_q.q[0].wbin))
    else $error("write taken while full");
  wr_step_a: assert property (
    wr_ok[1] |=> st_q.q[1].wbin == PW'($past(st_q.q[1].wbin) + 1'b1))
    else $error("write pointer did not step");
  rd_step_a: assert property (
    load[0] |=> st_q.q[0].rbin == PW'($past(st_q.q[0].rbin) + 1'b1))
    else $error("read pointer did not step on load");
  ft_ready_a: assert property (
    st_q.fall_through_mode && $rose(st_q.q[0].out_valid) |-> $past(load[0]))
    else $error("output-ready rose without a new word");

  wr_seen_c: cover property (wr_ok[0]);
  ft_load_c: cover property (st_q.fall_through_mode && load[1] && !st_q.q[1].out_valid);
  mbox_rd_c: cover property (mbr_req[1]);
  full_c:    cover property (!port_a_full_or_in_ready);
endmodule : bfs_flag_sync

// file: bfs_pkg.sv
// Purpose: Constants, types and helpers of the bidirectional queue flag block
// Assumes: Two queues, index 0 is A to B and index 1 is B to A
// Notes:   Pointers are kept wide enough for the deepest supported queue
package bfs_pkg;
  localparam int PTR_W     = 11;
  localparam int DATA_W    = 36;
  localparam int OFF_W     = 10;
  localparam int DEPTH_DEF = 256;
  localparam logic [OFF_W-1:0] OFF_RST = 10'h008;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OFF_AB = 8'h04;
  localparam logic [7:0] ADDR_OFF_BA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Field positions
  localparam int CTRL_FALL_THROUGH_MODE     = 0;
  localparam int OFF_EMPTY_LSB = 0;
  localparam int OFF_FULL_LSB  = 16;
  localparam int STAT_B_LSB    = 4;
  localparam int STAT_MB_LSB   = 8;
  // Direction level that means write, bit 0 port A, bit 1 port B
  localparam logic [1:0] WR_DIR = 2'h1;

  typedef struct packed {
    logic              clk;
    logic              select_n;
    logic              direction;
    logic              enable;
    logic              mailbox_select;
    logic [DATA_W-1:0] data;
  } bfs_pin_t;

  typedef struct packed {
    bfs_pin_t          s1;
    bfs_pin_t          s2;
    bfs_pin_t          s3;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } bfs_port_t;

  typedef struct packed {
    logic [PTR_W-1:0]  wbin;
    logic [PTR_W-1:0]  wgray;
    logic [PTR_W-1:0]  rbin;
    logic [PTR_W-1:0]  rgray;
    logic [PTR_W-1:0]  ws1;
    logic [PTR_W-1:0]  ws2;
    logic [PTR_W-1:0]  rs1;
    logic [PTR_W-1:0]  rs2;
    logic [DATA_W-1:0] dout;
    logic              out_valid;
  } bfs_queue_t;

  typedef struct packed {
    bfs_port_t  [1:0]             port;
    bfs_queue_t [1:0]             q;
    logic       [1:0][DATA_W-1:0] mb_data;
    logic       [1:0]             mb_full_n;
    logic                         fall_through_mode;
    logic       [1:0][OFF_W-1:0]  empty_off;
    logic       [1:0][OFF_W-1:0]  full_off;
    logic                         wr_pend;
    logic       [7:0]             waddr;
    logic       [31:0]            hrdata;
  } bfs_state_t;

  function automatic logic [PTR_W-1:0] bfs_to_gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bfs_to_gray

  function automatic logic [PTR_W-1:0] bfs_from_gray(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : bfs_from_gray
endpackage : bfs_pkg

// file: bfs_port_host.sv
// Purpose: Processor model on one port of the bidirectional queue block
// Assumes: Free-running port clock; controls change after a falling port edge
// Notes:   Released data lines show the inverse of their last value
`timescale 1ns/1ns
module bfs_port_host #(
  parameter int   HALF   = 80,
  parameter int   PHASE  = 7,
  parameter logic WR_LVL = 1'b1
) (
  // System
  input  wire logic                       hclk,
  // Port pins
  output logic                            clock,
  output logic                            select_n,
  output logic                            direction,
  output logic                            enable,
  output logic                            mailbox_select,
  output logic      [bfs_pkg::DATA_W-1:0] data_in,
  // Read side
  input  wire logic [bfs_pkg::DATA_W-1:0] data_out,
  input  wire logic                       data_oe
);
  initial begin
    clock          = 1'b0;
    select_n       = 1'b1;
    direction      = ~WR_LVL;
    enable         = 1'b0;
    mailbox_select = 1'b0;
    data_in        = '0;
    #PHASE;
    forever #HALF clock = ~clock;
  end

  // Waits n rising port edges, then until the flags have settled
  task automatic wait_edges(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
    repeat (2) @(posedge hclk);
  endtask : wait_edges

  // One access at the next rising port edge; q and oe are taken after it
  task automatic access(input logic wr, input logic mb, input logic en,
                        input logic [bfs_pkg::DATA_W-1:0] d,
                        output logic [bfs_pkg::DATA_W-1:0] q, output logic oe);
    @(negedge clock);
    @(posedge hclk);
    select_n       <= 1'b0;
    direction      <= wr ? WR_LVL : ~WR_LVL;
    enable         <= en;
    mailbox_select <= mb;
    data_in        <= wr ? d : ~data_in;
    @(posedge clock);
    @(negedge clock);
    repeat (2) @(posedge hclk);
    // Sample away from the edges that launch the outputs
    @(negedge hclk);
    q  = data_out;
    oe = data_oe;
    @(posedge hclk);
    select_n <= 1'b1;
    enable   <= 1'b0;
    data_in  <= ~data_in;
  endtask : access
endmodule : bfs_port_host

// file: tb_bidir_fifo_flag_sync.sv
// Purpose: Self-checking bench of the bidirectional queue flag block
// Assumes: Depth 256; port clocks run free at 160 ns, unrelated to hclk
// Notes:   Flag latencies are counted in edges of the port that owns the flag
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_bidir_fifo_flag_sync;
  localparam int DW = bfs_pkg::DATA_W;
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic          port_a_clock, port_a_select_n, port_a_direction, port_a_enable;
  logic          port_b_clock, port_b_select_n, port_b_direction, port_b_enable;
  logic          port_a_mailbox_select, port_a_data_oe, port_b_mailbox_select, port_b_data_oe;
  logic [DW-1:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
  logic          port_a_empty_or_out_ready, port_a_almost_empty_n;
  logic          port_a_full_or_in_ready, port_a_almost_full_n;
  logic          port_b_empty_or_out_ready, port_b_almost_empty_n;
  logic          port_b_full_or_in_ready, port_b_almost_full_n;
  logic          mailbox_one_full_n, mailbox_two_full_n;
  int            fails = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  bfs_flag_sync i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .port_a_clock, .port_a_select_n, .port_a_direction,
    .port_a_enable, .port_a_mailbox_select, .port_a_data_in, .port_a_data_out,
    .port_a_data_oe, .port_a_empty_or_out_ready, .port_a_almost_empty_n,
    .port_a_full_or_in_ready, .port_a_almost_full_n, .port_b_clock, .port_b_select_n,
    .port_b_direction, .port_b_enable, .port_b_mailbox_select, .port_b_data_in,
    .port_b_data_out, .port_b_data_oe, .port_b_empty_or_out_ready, .port_b_almost_empty_n,
    .port_b_full_or_in_ready, .port_b_almost_full_n, .mailbox_one_full_n, .mailbox_two_full_n);
  bfs_port_host i_host_a (
    .hclk, .clock(port_a_clock), .select_n(port_a_select_n), .direction(port_a_direction),
    .enable(port_a_enable), .mailbox_select(port_a_mailbox_select), .data_in(port_a_data_in),
    .data_out(port_a_data_out), .data_oe(port_a_data_oe));
  bfs_port_host #(.PHASE(33), .WR_LVL(bfs_pkg::WR_DIR[1])) i_host_b (
    .hclk, .clock(port_b_clock), .select_n(port_b_select_n), .direction(port_b_direction),
    .enable(port_b_enable), .mailbox_select(port_b_mailbox_select), .data_in(port_b_data_in),
    .data_out(port_b_data_out), .data_oe(port_b_data_oe));

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // Only the bench timeout ends a wait that never sees ready
  task automatic ahb_wait();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask : ahb_wait

  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    ahb_wait();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ahb_wait();
    rd = hrdata;
  endtask : ahb_xfer

  // Checks pin and register values after reset, and that an unmapped address reads zero
  task automatic t_reset();
    logic [31:0] r;
    // Second falling edge after release: first registered state out of reset
    repeat (2) @(negedge hclk);
    `CHK({port_a_data_oe, port_b_data_oe}, 2'b00)
    `CHK({port_a_almost_empty_n, port_b_almost_full_n, hresp}, 3'b010)
    ahb_xfer(1'b0, bfs_pkg::ADDR_CTRL, 32'h0, r);
    `CHK(r, 32'h0000_0000)
    ahb_xfer(1'b0, bfs_pkg::ADDR_OFF_AB, 32'h0, r);
    `CHK(r, 32'h0008_0008)
    ahb_xfer(1'b0, bfs_pkg::ADDR_OFF_BA, 32'h0, r);
    `CHK(r, 32'h0008_0008)
    ahb_xfer(1'b1, 8'h10, 32'hFFFF_FFFF, r);
    ahb_xfer(1'b0, 8'h10, 32'h0, r);
    `CHK(r, 32'h0000_0000)
    ahb_xfer(1'b0, bfs_pkg::ADDR_STATUS, 32'h0, r);
    `CHK(r, 32'h0000_03CC)
  endtask : t_reset

  task automatic t_std();
    logic [DW-1:0] q;
    logic          oe;
    int            n;
    fork
      i_host_a.access(1'b1, 1'b0, 1'b1, 36'h9_1234_5678, q, oe);
      begin
        @(negedge port_a_clock);
        @(posedge port_a_clock);
        n = 0;
        do begin
          i_host_b.wait_edges(1);
          n++;
        end while (port_b_empty_or_out_ready !== 1'b1 && n < 5);
      end
    join
    `CHK(n >= 2 && n <= 3, 1'b1)
    i_host_b.access(1'b0, 1'b0, 1'b1, '0, q, oe);
    `CHK(q, 36'h9_1234_5678)
    `CHK(oe, 1'b1)
    `CHK(port_b_empty_or_out_ready, 1'b0)
    i_host_b.access(1'b0, 1'b0, 1'b1, '0, q, oe);
    `CHK(q, 36'h9_1234_5678)
    i_host_b.wait_edges(0);
    `CHK(port_b_data_oe, 1'b0)
  endtask : t_std

  task automatic t_fall_through_mode();
    logic [DW-1:0] q;
    logic [31:0]   r;
    logic          oe;
    int            n;
    ahb_xfer(1'b1, bfs_pkg::ADDR_CTRL, 32'h1, r);
    fork
      i_host_b.access(1'b1, 1'b0, 1'b1, 36'h6_0F0F_0F0F, q, oe);
      begin
        @(negedge port_b_clock);
        @(posedge port_b_clock);
        n = 0;
        do begin
          i_host_a.wait_edges(1);
          n++;
        end while (port_a_empty_or_out_ready !== 1'b1 && n < 6);
      end
    join
    `CHK(n >= 3 && n <= 4, 1'b1)
    `CHK(port_a_data_out, 36'h6_0F0F_0F0F)
    `CHK(port_b_full_or_in_ready, 1'b1)
    i_host_a.access(1'b0, 1'b0, 1'b1, '0, q, oe);
    `CHK(q, 36'h6_0F0F_0F0F)
    `CHK(port_a_empty_or_out_ready, 1'b0)
    i_host_a.access(1'b0, 1'b0, 1'b1, '0, q, oe);
    `CHK(q, 36'h6_0F0F_0F0F)
    ahb_xfer(1'b1, bfs_pkg::ADDR_CTRL, 32'h0, r);
  endtask : t_fall_through_mode

  task automatic t_fill();
    logic [DW-1:0] q;
    logic [31:0]   r;
    logic          oe;
    int            n;
    ahb_xfer(1'b1, bfs_pkg::ADDR_OFF_AB, 32'h0005_0003, r);
    for (int k = 1; k <= 257; k++) begin
      i_host_a.access(1'b1, 1'b0, 1'b1, 36'(k), q, oe);
      `CHK(port_a_almost_full_n, 1'(k < 251))
      `CHK(port_a_full_or_in_ready, 1'(k < 256))
    end
    `CHK(port_b_almost_empty_n, 1'b1)
    fork
      i_host_b.access(1'b0, 1'b0, 1'b1, '0, q, oe);
      begin
        @(negedge port_b_clock);
        @(posedge port_b_clock);
        n = 0;
        do begin
          i_host_a.wait_edges(1);
          n++;
        end while (port_a_full_or_in_ready !== 1'b1 && n < 5);
      end
    join
    `CHK(n >= 2 && n <= 3, 1'b1)
    `CHK(q, 36'(1))
    for (int k = 2; k <= 256; k++) begin
      i_host_b.access(1'b0, 1'b0, 1'b1, '0, q, oe);
      `CHK(q, 36'(k))
      `CHK(port_b_almost_empty_n, 1'(256 - k > 3))
    end
    `CHK(port_b_empty_or_out_ready, 1'b0)
  endtask : t_fill

  task automatic t_mail();
    logic [DW-1:0] q;
    logic          oe;
    i_host_a.access(1'b1, 1'b1, 1'b1, 36'hA_AAAA_0001, q, oe);
    `CHK(mailbox_one_full_n, 1'b0)
    i_host_a.access(1'b1, 1'b1, 1'b1, 36'hA_AAAA_0002, q, oe);
    i_host_a.access(1'b1, 1'b0, 1'b0, 36'hA_AAAA_0003, q, oe);
    i_host_b.access(1'b0, 1'b1, 1'b1, '0, q, oe);
    `CHK(q, 36'hA_AAAA_0001)
    `CHK(mailbox_one_full_n, 1'b1)
    i_host_b.access(1'b1, 1'b1, 1'b1, 36'h5_5555_0004, q, oe);
    `CHK(mailbox_two_full_n, 1'b0)
    i_host_a.access(1'b0, 1'b1, 1'b1, '0, q, oe);
    `CHK(q, 36'h5_5555_0004)
    `CHK(mailbox_two_full_n, 1'b1)
    i_host_b.wait_edges(3);
    `CHK(port_b_empty_or_out_ready, 1'b0)
    `CHK(port_a_data_oe, 1'b0)
  endtask : t_mail

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    hsize   = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_std();
    t_fall_through_mode();
    t_fill();
    t_mail();
    summarize();
  end
endmodule : tb_bidir_fifo_flag_sync
